//--- design/ppt_pkg.sv
// Purpose: constants and types for the dual 8-bit pulse generator / cascaded timer
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit registers in the low byte
// Notes:   one package shared by the single design file
//
// Functional notes
// R01 - channel runs as 8-bit pulse generator with mode 10, cascade 0, event select 0
// R02 - duty compare sets pulse width, period compare sets cycle width
// R03 - writes to a channel's mode register are ignored while its run bit is set
// R04 - initial-level bit gives idle pin level, 0 low, 1 high, shown while stopped
// R05 - output-AND bit drives the pulse pin with AND of both channel outputs
// R06 - counter steps on selected clock; duty match flips output away from initial level
// R07 - period match returns output to initial level and raises channel interrupt
// R08 - period match clears the counter to zero and counting resumes
// R09 - clearing run stops counter, clears it to 0x00, pin back to initial level
// R10 - buffer-enable bit turns double buffering of duty and period on or off
// R11 - buffered running writes go to buffer; active value loads at period event
// R12 - with buffering on, compare reads return the buffered last-written value
// R13 - buffered write while stopped updates buffer and active value together
// R14 - unbuffered running write acts at once; value below count waits for wraparound
// R15 - unbuffered write equal to count matches right after the write
// R16 - cascade bit joins channels into 16 bits; high channel settings govern
// R17 - 16-bit timer needs high mode 00 or 01, event select 0, high clock select
// R18 - 16-bit compare is high byte over low byte, both taken on high byte write
// R19 - software writes low compare byte first, then high compare byte
// R20 - in 16-bit mode high run starts; high mode writes ignored while running
// R21 - 16-bit match raises high interrupt, clears to 0x0000; run clear stops and clears
// R22 - buffered 16-bit running writes wait in buffer until the match event
// R23 - buffered 16-bit write while stopped updates buffer and active value at once
// R24 - unbuffered 16-bit running write takes effect at once
// R25 - reading the 16-bit compare returns the last written value
package ppt_pkg;

  // register byte offsets
  localparam logic [5:0] OFF_LOW_MODE   = 6'h00;
  localparam logic [5:0] OFF_HIGH_MODE  = 6'h04;
  localparam logic [5:0] OFF_PAIR_CTRL  = 6'h08;
  localparam logic [5:0] OFF_LOW_PER    = 6'h0C;
  localparam logic [5:0] OFF_LOW_DUTY   = 6'h10;
  localparam logic [5:0] OFF_HIGH_PER   = 6'h14;
  localparam logic [5:0] OFF_HIGH_DUTY  = 6'h18;
  localparam logic [5:0] OFF_WIDE_CMP   = 6'h1C;
  localparam logic [5:0] OFF_STATUS     = 6'h20;

  // reset values
  localparam logic [7:0] MODE_RESET     = 8'h00;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] CMP_RESET      = 8'h00;

  // mode encodings
  localparam logic [1:0] MODE_PPG       = 2'h2;

  // prescaler width, longest division is 2^11
  localparam int         PRESCALE_W     = 11;

  // axi responses
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // channel mode register layout, msb first
  typedef struct packed {
    logic       initial_level;
    logic       buffer_enable;
    logic [2:0] clock_select;
    logic       event_input_select;
    logic [1:0] mode_select;
  } ppt_mode_t;

  // pair control register layout, msb first
  typedef struct packed {
    logic [3:0] unused;
    logic       output_and_select;
    logic       cascade_select;
    logic       high_run_bit;
    logic       low_run_bit;
  } ppt_ctrl_t;

endpackage

//--- design/ppt_timer.sv
// Purpose: pair of 8-bit pulse generator channels, cascadable into a 16-bit timer
// Assumes: single clock aclk, synchronous active-low reset, AXI4-Lite slave
// Notes:   interrupt pulses are registered one aclk after the event, pins two aclk after
//
// The AXI4-Lite register port and the register offsets were decided locally.
module ppt_timer #(
  parameter int ADDR_W = 6
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   pulse_output_pin,
  output logic                   high_pulse_pin,
  output logic                   low_channel_irq,
  output logic                   high_channel_irq
);

  // the decode compares 6-bit offsets, so narrower addresses cannot work
  if (ADDR_W < 6) begin : g_chk
    $error("ADDR_W must be at least 6");
  end

  localparam int PRESCALE_W = ppt_pkg::PRESCALE_W;

  // prescaler tap for a clock select code, one-cycle enable
  function automatic logic tick_of(input logic [2:0] sel,
                                   input logic [PRESCALE_W-1:0] pre);
    logic t;
    t = 1'b0;
    case (sel)
      3'h0:    t = &pre[10:0];
      3'h1:    t = &pre[9:0];
      3'h2:    t = &pre[7:0];
      3'h3:    t = &pre[5:0];
      3'h4:    t = &pre[3:0];
      3'h5:    t = &pre[1:0];
      3'h6:    t = pre[0];
      default: t = 1'b1;
    endcase
    return t;
  endfunction

  // bus state
  logic              aw_hold_reg;
  logic              w_hold_reg;
  logic [5:0]        wr_addr_reg;
  logic [7:0]        wr_data_reg;
  logic              wr_byte_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              wr_fire;

  // block state
  logic [PRESCALE_W-1:0] pre_reg;
  ppt_pkg::ppt_mode_t    mode_reg [2];
  ppt_pkg::ppt_ctrl_t    ctrl_reg;
  logic [7:0]        per_buf_reg  [2];
  logic [7:0]        per_act_reg  [2];
  logic [7:0]        duty_buf_reg [2];
  logic [7:0]        duty_act_reg [2];
  logic [7:0]        low_stage_reg;
  logic [7:0]        cnt_reg      [2];
  logic [7:0]        cnt_next     [2];
  logic [1:0]        cnt_chg_reg;
  logic [1:0]        cmp_chg_reg;
  logic [1:0]        on_prev_reg;
  logic [1:0]        out_reg;
  logic              pin0_reg;
  logic              pin1_reg;
  logic              irq0_reg;
  logic              irq1_reg;

  // derived control
  logic              cascade;
  logic [1:0]        run;
  logic [1:0]        ppg_on;
  logic              wide_on;
  logic [1:0]        tick;
  logic [1:0]        eff_run;
  logic [1:0]        eff_dbe;
  logic [1:0]        eval;
  logic [1:0]        per_hit;
  logic [1:0]        duty_hit;
  logic              wide_hit;
  logic [15:0]       wide_cnt;
  logic [15:0]       wide_act;
  logic [1:0]        on_now;

  // ---------------- axi4-lite slave ----------------

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign wr_fire       = aw_hold_reg && w_hold_reg && !bvalid_reg;

  // address and data may arrive in either order; hold each until both are here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      wr_addr_reg <= 6'h00;
      wr_data_reg <= 8'h00;
      wr_byte_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        wr_addr_reg <= s_axi_awaddr[5:0];
      end else if (wr_fire) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg  <= 1'b1;
        wr_data_reg <= s_axi_wdata[7:0];
        wr_byte_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // write response; unmapped offsets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= ppt_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_addr_reg <= ppt_pkg::OFF_STATUS && wr_addr_reg[1:0] == 2'h0)
                    ? ppt_pkg::RESP_OKAY : ppt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read path, one cycle from address to data, no read side effects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= ppt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= ppt_pkg::RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
      case (s_axi_araddr[5:0])
        ppt_pkg::OFF_LOW_MODE:  rdata_reg[7:0] <= mode_reg[0];
        ppt_pkg::OFF_HIGH_MODE: rdata_reg[7:0] <= mode_reg[1];
        ppt_pkg::OFF_PAIR_CTRL: rdata_reg[7:0] <= ctrl_reg;
        ppt_pkg::OFF_LOW_PER:   rdata_reg[7:0] <= per_buf_reg[0];  // R12
        ppt_pkg::OFF_LOW_DUTY:  rdata_reg[7:0] <= duty_buf_reg[0]; // R12
        ppt_pkg::OFF_HIGH_PER:  rdata_reg[7:0] <= per_buf_reg[1];  // R12
        ppt_pkg::OFF_HIGH_DUTY: rdata_reg[7:0] <= duty_buf_reg[1]; // R12
        ppt_pkg::OFF_WIDE_CMP:  rdata_reg[15:0] <= {per_buf_reg[1], per_buf_reg[0]}; // R25
        ppt_pkg::OFF_STATUS:    rdata_reg[17:0] <= {pin1_reg, pin0_reg,
                                                    cnt_reg[1], cnt_reg[0]};
        default:                rresp_reg <= ppt_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------- control decode ----------------

  assign cascade  = ctrl_reg.cascade_select;
  assign run      = {ctrl_reg.high_run_bit, ctrl_reg.low_run_bit};
  assign wide_cnt = {cnt_reg[1], cnt_reg[0]};
  assign wide_act = {per_act_reg[1], per_act_reg[0]};

  // high channel settings govern the pair when cascaded
  assign wide_on = cascade && !mode_reg[1].mode_select[1]        // R16 R17
                   && !mode_reg[1].event_input_select && run[1];
  assign eval    = cnt_chg_reg | cmp_chg_reg;
  assign wide_hit = wide_on && (|eval) && (wide_cnt == wide_act); // R21

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ppg_on[i]   = !cascade && mode_reg[i].mode_select == ppt_pkg::MODE_PPG
                    && !mode_reg[i].event_input_select && run[i];  // R01
      tick[i]     = tick_of(mode_reg[i].clock_select, pre_reg);
      eff_run[i]  = cascade ? run[1] : run[i];
      eff_dbe[i]  = cascade ? mode_reg[1].buffer_enable
                            : mode_reg[i].buffer_enable;           // R10
      // match is only looked at when count or compare just moved, so an
      // equal compare written mid-count still fires once
      per_hit[i]  = ppg_on[i] && eval[i] && cnt_reg[i] == per_act_reg[i];  // R07 R15
      duty_hit[i] = ppg_on[i] && eval[i] && cnt_reg[i] == duty_act_reg[i]; // R06 R15
      on_now[i]   = cascade ? wide_on : ppg_on[i];
    end
  end

  // counter next value; clear beats increment
  always_comb begin
    cnt_next[0] = cnt_reg[0];
    cnt_next[1] = cnt_reg[1];
    if (cascade) begin
      if (!wide_on || wide_hit) begin                              // R21
        cnt_next[0] = 8'h00;
        cnt_next[1] = 8'h00;
      end else if (tick[1]) begin                                  // R17
        {cnt_next[1], cnt_next[0]} = wide_cnt + 16'h0001;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!ppg_on[i] || per_hit[i]) begin                        // R08 R09
          cnt_next[i] = 8'h00;
        end else if (tick[i]) begin                                // R06 R14
          cnt_next[i] = cnt_reg[i] + 8'h01;
        end
      end
    end
  end

  // ---------------- prescaler ----------------

  // free running; every slower rate is a tap of this counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 11'h001;
    end
  end

  // ---------------- configuration registers ----------------

  // mode is frozen while the channel runs, so the period cannot shift mid-cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg[0] <= ppt_pkg::MODE_RESET;
      mode_reg[1] <= ppt_pkg::MODE_RESET;
      ctrl_reg    <= ppt_pkg::CTRL_RESET;
    end else if (wr_fire && wr_byte_reg) begin
      if (wr_addr_reg == ppt_pkg::OFF_LOW_MODE && !run[0]) begin  // R03
        mode_reg[0] <= wr_data_reg;
      end
      if (wr_addr_reg == ppt_pkg::OFF_HIGH_MODE && !run[1]) begin // R03 R20
        mode_reg[1] <= wr_data_reg;
      end
      if (wr_addr_reg == ppt_pkg::OFF_PAIR_CTRL) begin
        ctrl_reg <= {4'h0, wr_data_reg[3:0]};
      end
    end
  end

  // ---------------- compare registers ----------------

  // buffer takes each write except a cascaded low period byte, which waits in low_stage_reg; active copy follows unless buffered and running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2; i++) begin
        per_buf_reg[i]  <= ppt_pkg::CMP_RESET;
        per_act_reg[i]  <= ppt_pkg::CMP_RESET;
        duty_buf_reg[i] <= ppt_pkg::CMP_RESET;
        duty_act_reg[i] <= ppt_pkg::CMP_RESET;
      end
      low_stage_reg <= ppt_pkg::CMP_RESET;
      cmp_chg_reg   <= 2'h0;
    end else begin
      cmp_chg_reg <= 2'h0;
      // period event loads the buffered values
      for (int i = 0; i < 2; i++) begin
        if (per_hit[i] && eff_dbe[i]) begin                        // R11
          per_act_reg[i]  <= per_buf_reg[i];
          duty_act_reg[i] <= duty_buf_reg[i];
        end
      end
      if (wide_hit && eff_dbe[1]) begin                            // R22
        per_act_reg[0] <= per_buf_reg[0];
        per_act_reg[1] <= per_buf_reg[1];
      end
      if (wr_fire && wr_byte_reg) begin
        case (wr_addr_reg)
          ppt_pkg::OFF_LOW_PER: begin
            if (cascade) begin
              low_stage_reg <= wr_data_reg;                        // R18 R19
            end else begin
              per_buf_reg[0] <= wr_data_reg;
              if (!(eff_dbe[0] && eff_run[0])) begin               // R13 R14
                per_act_reg[0]  <= wr_data_reg;
                cmp_chg_reg[0]  <= 1'b1;
              end
            end
          end
          ppt_pkg::OFF_HIGH_PER: begin
            per_buf_reg[1] <= wr_data_reg;
            if (cascade) begin
              per_buf_reg[0] <= low_stage_reg;                     // R18
            end
            if (!(eff_dbe[1] && eff_run[1])) begin                 // R13 R23 R24
              per_act_reg[1]  <= wr_data_reg;
              cmp_chg_reg[1]  <= 1'b1;
              if (cascade) begin
                per_act_reg[0] <= low_stage_reg;                   // R18
              end
            end
          end
          ppt_pkg::OFF_LOW_DUTY: begin
            duty_buf_reg[0] <= wr_data_reg;                        // R02
            if (!(eff_dbe[0] && eff_run[0])) begin                 // R13 R14
              duty_act_reg[0] <= wr_data_reg;
              cmp_chg_reg[0]  <= 1'b1;
            end
          end
          ppt_pkg::OFF_HIGH_DUTY: begin
            duty_buf_reg[1] <= wr_data_reg;                        // R02
            if (!(eff_dbe[1] && eff_run[1])) begin                 // R13 R14
              duty_act_reg[1] <= wr_data_reg;
              cmp_chg_reg[1]  <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ---------------- counters ----------------

  // change marks arm the match compare for exactly one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg[0]  <= 8'h00;
      cnt_reg[1]  <= 8'h00;
      cnt_chg_reg <= 2'h0;
      on_prev_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        cnt_reg[i]     <= cnt_next[i];
        cnt_chg_reg[i] <= (cnt_next[i] != cnt_reg[i]) || (on_now[i] && !on_prev_reg[i]);
        on_prev_reg[i] <= on_now[i];
      end
    end
  end

  // ---------------- outputs ----------------

  // period match wins over duty match in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!ppg_on[i] || per_hit[i]) begin                        // R04 R07 R09
          out_reg[i] <= mode_reg[i].initial_level;
        end else if (duty_hit[i]) begin                            // R06
          out_reg[i] <= !mode_reg[i].initial_level;
        end
      end
    end
  end

  // pins registered once more so they never glitch on decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin0_reg <= 1'b0;
      pin1_reg <= 1'b0;
    end else begin
      pin0_reg <= ctrl_reg.output_and_select ? (out_reg[0] & out_reg[1]) : out_reg[0]; // R05
      pin1_reg <= out_reg[1];
    end
  end

  // interrupt requests are one-cycle pulses at the period or wide match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
    end else begin
      irq0_reg <= per_hit[0];                                      // R07
      irq1_reg <= per_hit[1] || wide_hit;                          // R07 R21
    end
  end

  assign pulse_output_pin = pin0_reg;
  assign high_pulse_pin   = pin1_reg;
  assign low_channel_irq  = irq0_reg;
  assign high_channel_irq = irq1_reg;

endmodule

//--- tb/ppt_timer_asserts.sv
// Purpose: bus handshake and interrupt pulse checks on the timer pair ports
// Assumes: one clock, synchronous active-low reset
// Notes:   pins are judged by the bench, which knows the programmed mode
module ppt_timer_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       low_channel_irq,
  input wire logic       high_channel_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a pending answer must wait for the master
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  // one transfer of each kind at a time
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken while answer pending");
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read taken while answer pending");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  // data held alone blocks further data until the address arrives
  property p_w_held;
    s_axi_wvalid && s_axi_wready && !(s_axi_awvalid && s_axi_awready) |=> !s_axi_wready;
  endproperty
  a_w_held: assert property (p_w_held) else $error("second data taken");
  property p_low_irq;
    low_channel_irq |=> !low_channel_irq;
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("low irq not a pulse");
  property p_high_irq;
    high_channel_irq |=> !high_channel_irq;
  endproperty
  a_high_irq: assert property (p_high_irq) else $error("high irq not a pulse");
endmodule

bind ppt_timer ppt_timer_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .low_channel_irq(low_channel_irq),
  .high_channel_irq(high_channel_irq));

//--- tb/tb.sv
// Purpose: self-checking bench for the pulse generator pair and 16-bit timer
// Assumes: clock select 7 steps the counter on every aclk
// Notes:   widths are counted at negedge, between the irq pulses
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = ppt_pkg::RESP_OKAY;
  localparam logic [1:0] SE = ppt_pkg::RESP_SLVERR;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [5:0]  awaddr = 6'h00;
  logic [5:0]  araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, d;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, pin, hpin, lirq, hirq;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  m;
  int          fails = 0, samples_checked = 0, lo_cnt = 0, hi, len, l1, bad, ones;
  logic [5:0]  ra [11] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20,
                           6'h22, 6'h24};
  logic [7:0]  rw [11] = '{8'h3A, 8'h3A, 8'hF0, 8'h05, 8'h02, 8'h06, 8'h03, 8'h55, 8'hFF,
                           8'h11, 8'h11};
  logic [7:0]  re [11] = '{8'h3A, 8'h3A, 8'h00, 8'h05, 8'h02, 8'h06, 8'h03, 8'h00, 8'h00,
                           8'h00, 8'h00};
  logic [1:0]  rr [11] = '{OK, OK, OK, OK, OK, OK, OK, OK, OK, SE, SE};

  always #2 aclk = ~aclk;
  // low irqs that should stay silent while cascaded
  always @(negedge aclk) if (lirq === 1'h1) lo_cnt++;

  ppt_timer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pulse_output_pin(pin), .high_pulse_pin(hpin), .low_channel_irq(lirq),
    .high_channel_irq(hirq));

  task automatic end_sim;
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // ready is sampled at negedge so the next rising edge is the handshake
  task automatic wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rs,
                    input bit wf = 0);
    bit pa, pw, ta, tw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= !wf;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && awvalid && awready;
      tw = pw && wready;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'h0;
        pa = 0;
      end
      if (tw) begin
        wvalid <= 1'h0;
        pw = 0;
        if (wf) awvalid <= 1'h1;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'h1);
    rs = bresp;
    @(posedge aclk);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge aclk); while (arready !== 1'h1);
    @(posedge aclk);
    arvalid <= 1'h0;
    do @(negedge aclk); while (rvalid !== 1'h1);
    v = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask

  // cycles away from the idle level, counted up to the next irq
  task automatic meas(input bit h, input logic lv, output int nh, output int n);
    nh = 0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      if ((h ? hpin : pin) !== lv) nh++;
    end while ((h ? hirq : lirq) !== 1'h1 && n < 3000);
  endtask

  initial begin
    #100000;
    fails++;
    end_sim;
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    // register table: reset value, write answer, read back
    for (int i = 0; i < 11; i++) begin
      rd(ra[i], d, r);
      if (rr[i] === OK) chk("reset value", d, (i == 7) ? {16'h0, re[5], re[3]} : 32'h0);
      wr(ra[i], {24'h0, rw[i]}, r, i == 3);
      chk("write resp", 32'(r), 32'(rr[i]));
      rd(ra[i], d, r);
      chk("read resp", 32'(r), 32'(rr[i]));
      if (rr[i] === OK) chk("read back", d, (i == 7) ? {16'h0, re[5], re[3]} : {24'h0, re[i]});
    end
    // pulse generator: init low, init high, buffered
    for (int i = 0; i < 3; i++) begin
      m = (i == 1) ? 8'hBA : (i == 2) ? 8'h7A : 8'h3A;
      wr(6'h00, {24'h0, m}, r);
      wr(6'h0C, 32'h28, r);
      wr(6'h10, 32'h0A, r);
      wr(6'h08, 32'h01, r);
      meas(0, m[7], hi, len);
      meas(0, m[7], hi, len);
      chk("duty width", hi, 32'h1E);
      wr(6'h10, 32'h1E, r);
      meas(0, m[7], hi, len);
      chk("width after write", hi, m[6] ? 32'h1E : 32'h0A);
      meas(0, m[7], hi, len);
      chk("width next cycle", hi, 32'h0A);
      rd(6'h10, d, r);
      chk("duty read", d, 32'h1E);
      wr(6'h00, {24'h0, m ^ 8'h40}, r);
      rd(6'h00, d, r);
      chk("mode locked", d, {24'h0, m});
      wr(6'h08, 32'h00, r);
      repeat (3) @(negedge aclk);
      chk("idle pin", 32'(pin), 32'(m[7]));
      rd(6'h20, d, r);
      chk("stopped count", 32'(d[7:0]), 32'h0);
    end
    // output AND with the high channel running, then stopped
    wr(6'h04, 32'h3A, r);
    wr(6'h14, 32'h28, r);
    wr(6'h18, 32'h14, r);
    for (int k = 0; k < 2; k++) begin
      wr(6'h08, k ? 32'h09 : 32'h0B, r);
      repeat (4) @(negedge aclk);
      bad = 0;
      ones = 0;
      repeat (400) begin
        @(negedge aclk);
        if (pin && !hpin) bad++;
        if (pin) ones++;
      end
      chk("and leak", bad, 32'h0);
      chk("and ones", 32'(ones != 0), 32'(k == 0));
    end
    // cascaded 16-bit timer
    wr(6'h08, 32'h04, r);
    wr(6'h04, 32'h38, r);
    wr(6'h0C, 32'h10, r);
    wr(6'h14, 32'h00, r);
    wr(6'h0C, 32'h30, r);
    rd(6'h1C, d, r);
    chk("wide compare", d, 32'h10);
    wr(6'h0C, 32'h10, r);
    wr(6'h14, 32'h00, r);
    lo_cnt = 0;
    wr(6'h08, 32'h06, r);
    meas(1, 1'h0, hi, l1);
    meas(1, 1'h0, hi, l1);
    wr(6'h0C, 32'h20, r);
    wr(6'h14, 32'h00, r);
    meas(1, 1'h0, hi, len);
    meas(1, 1'h0, hi, len);
    chk("interval step", len - l1, 32'h10);
    chk("low irq cascaded", lo_cnt, 32'h0);
    wr(6'h08, 32'h04, r);
    repeat (3) @(negedge aclk);
    rd(6'h20, d, r);
    chk("wide stopped", 32'(d[15:0]), 32'h0);
    // buffered 16-bit compare
    wr(6'h04, 32'h78, r);
    wr(6'h0C, 32'h10, r);
    wr(6'h14, 32'h00, r);
    wr(6'h08, 32'h06, r);
    meas(1, 1'h0, hi, len);
    meas(1, 1'h0, hi, len);
    chk("buffered start", len, 32'h11);
    wr(6'h0C, 32'h20, r);
    wr(6'h14, 32'h00, r);
    meas(1, 1'h0, hi, len);
    chk("buffered hold", 32'(len < 17), 32'h1);
    meas(1, 1'h0, hi, len);
    chk("buffered load", len, 32'h21);
    end_sim;
  end
endmodule
